/* verilog/adma_top.sv */
// four descriptor-driven audio dma channels with byte register port
`timescale 1ns/10ps
`default_nettype none
module adma_top (
  input wire logic CLK_SYS_I,
  input wire logic RESETN_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire logic [7:0] REG_WDATA_I,
  output logic [7:0] REG_RDATA_O,
  input wire logic CH4_ALT_SLOT_I,
  input wire logic CH5_ALT_SLOT_I,
  input wire logic SLOT_TICK_I,
  input wire logic [3:0] SLOT_NUM_I,
  input wire logic [15:0] SLOT_IN_I,
  output logic [15:0] SLOT_OUT_O,
  output logic SLOT_OUT_VLD_O,
  output logic MEM_REQ_O,
  output logic MEM_WE_O,
  output logic [31:0] MEM_ADDR_O,
  output logic [31:0] MEM_WDATA_O,
  output logic [3:0] MEM_BE_O,
  input wire logic MEM_GNT_I,
  input wire logic MEM_RVALID_I,
  input wire logic [31:0] MEM_RDATA_I
);
  logic [7:0] cmd_reg [adma_pkg::NCH];
  logic [1:0] stat_reg [adma_pkg::NCH];
  logic [31:0] ptr_reg [adma_pkg::NCH];
  logic [7:0] rd_next;
  logic [3:0] en;
  logic [3:0] dir;
  logic [3:0] stat_rd;
  logic [3:0] slot_hit;
  logic [3:0] eop_evt;
  logic [3:0] err_evt;
  logic [3:0] ptr_adv;
  logic [3:0] hold_full;
  logic [15:0] hold_data [adma_pkg::NCH];
  adma_pkg::adma_ch_state_t ch_st [adma_pkg::NCH];

  adma_mem_if mif ();

  function automatic logic ptr_hit(input logic [7:0] a, input int i);
    return a[7:2] == adma_pkg::PTR_OFS[i][7:2];
  endfunction

  function automatic logic [3:0] slot_of(input int i, input logic alt4, input logic alt5);
    logic [3:0] s;
    s = adma_pkg::SLOT_PRI;
    if (i == 2) begin
      s = alt4 ? adma_pkg::SLOT_ALT_B : adma_pkg::SLOT_ALT_A;
    end else if (i == 3) begin
      s = alt5 ? adma_pkg::SLOT_ALT_B : adma_pkg::SLOT_ALT_A;
    end
    return s;
  endfunction

  always_comb begin
    for (int i = 0; i < adma_pkg::NCH; i++) begin
      en[i] = cmd_reg[i][adma_pkg::CMD_EN_BIT];
      dir[i] = cmd_reg[i][adma_pkg::CMD_DIR_BIT];
      stat_rd[i] = REG_RD_I && (REG_ADDR_I == adma_pkg::STAT_OFS[i]);
      // channel 2 and 3 sit on the primary slot, 4 and 5 on a chosen one
      slot_hit[i] = SLOT_TICK_I && en[i] && (SLOT_NUM_I == slot_of(i, CH4_ALT_SLOT_I,
                    CH5_ALT_SLOT_I));
    end
  end

  // command registers: only enable and direction are stored
  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      for (int i = 0; i < adma_pkg::NCH; i++) begin
        cmd_reg[i] <= adma_pkg::CMD_RST;
      end
    end else begin
      for (int i = 0; i < adma_pkg::NCH; i++) begin
        if (REG_WR_I && REG_ADDR_I == adma_pkg::CMD_OFS[i]) begin
          cmd_reg[i] <= REG_WDATA_I & adma_pkg::CMD_MASK;
        end
      end
    end
  end

  // status flags: a new event in the read cycle survives the clear
  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      for (int i = 0; i < adma_pkg::NCH; i++) begin
        stat_reg[i] <= adma_pkg::STAT_RST;
      end
    end else begin
      for (int i = 0; i < adma_pkg::NCH; i++) begin
        stat_reg[i] <= (stat_rd[i] ? 2'h0 : stat_reg[i]) | {err_evt[i], eop_evt[i]};
      end
    end
  end

  // software byte writes win over a same-cycle hardware advance
  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      for (int i = 0; i < adma_pkg::NCH; i++) begin
        ptr_reg[i] <= adma_pkg::PTR_RST;
      end
    end else begin
      for (int i = 0; i < adma_pkg::NCH; i++) begin
        if (REG_WR_I && ptr_hit(REG_ADDR_I, i)) begin
          ptr_reg[i][{REG_ADDR_I[1:0], 3'b000} +: 8] <= REG_WDATA_I;
          if (REG_ADDR_I[1:0] == 2'b00) begin
            ptr_reg[i][1:0] <= 2'b00;
          end
        end else if (ptr_adv[i]) begin
          ptr_reg[i] <= ptr_reg[i] + adma_pkg::PTR_STEP;
        end
      end
    end
  end

  always_comb begin
    rd_next = 8'h00;
    for (int i = 0; i < adma_pkg::NCH; i++) begin
      if (REG_ADDR_I == adma_pkg::CMD_OFS[i]) begin
        rd_next = cmd_reg[i] & adma_pkg::CMD_MASK;
      end else if (REG_ADDR_I == adma_pkg::STAT_OFS[i]) begin
        rd_next = {6'h00, stat_reg[i]};
      end else if (ptr_hit(REG_ADDR_I, i)) begin
        rd_next = ptr_reg[i][{REG_ADDR_I[1:0], 3'b000} +: 8];
      end
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      REG_RDATA_O <= 8'h00;
    end else if (REG_RD_I) begin
      REG_RDATA_O <= rd_next;
    end
  end

  // codec side: an empty output stage answers its slot with no valid
  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      SLOT_OUT_O <= 16'h0;
      SLOT_OUT_VLD_O <= 1'b0;
    end else begin
      SLOT_OUT_VLD_O <= 1'b0;
      for (int i = 0; i < adma_pkg::NCH; i++) begin
        if (slot_hit[i] && !dir[i] && hold_full[i]) begin
          SLOT_OUT_O <= hold_data[i];
          SLOT_OUT_VLD_O <= 1'b1;
        end
      end
    end
  end

  for (genvar g = 0; g < adma_pkg::NCH; g++) begin : g_ch
    adma_pkg::adma_ch_state_t st_reg;
    logic [31:0] baddr_reg;
    logic [15:0] cnt_reg;
    logic eop_reg;
    logic eot_reg;
    logic req_reg;
    logic we_reg;
    logic [31:0] addr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] be_reg;
    logic eop_evt_reg;
    logic err_evt_reg;
    logic adv_reg;
    logic push;
    logic pop;
    logic [15:0] push_data;
    logic ack;

    assign ack = mif.ack[g];
    // output channels fill from memory, input channels fill from the codec
    assign push = dir[g] ? slot_hit[g] : (ack && !we_reg && st_reg == adma_pkg::ST_MOVE);
    assign pop = dir[g] ? (ack && we_reg && st_reg == adma_pkg::ST_MOVE)
                        : (slot_hit[g] && hold_full[g]);
    assign push_data = dir[g] ? SLOT_IN_I
                              : (baddr_reg[1] ? mif.rdata[31:16] : mif.rdata[15:0]);

    adma_hold u_hold (
      .clk_i(CLK_SYS_I),
      .rst_n_i(RESETN_I),
      .push_i(push),
      .pop_i(pop),
      .data_i(push_data),
      .full_o(hold_full[g]),
      .data_o(hold_data[g])
    );

    always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
        st_reg <= adma_pkg::ST_IDLE;
        baddr_reg <= 32'h0;
        cnt_reg <= 16'h0;
        eop_reg <= 1'b0;
        eot_reg <= 1'b0;
        req_reg <= 1'b0;
        we_reg <= 1'b0;
        addr_reg <= 32'h0;
        wdata_reg <= 32'h0;
        be_reg <= 4'h0;
        eop_evt_reg <= 1'b0;
        err_evt_reg <= 1'b0;
        adv_reg <= 1'b0;
      end else begin
        eop_evt_reg <= 1'b0;
        err_evt_reg <= 1'b0;
        adv_reg <= 1'b0;
        case (st_reg)
          adma_pkg::ST_IDLE: begin
            if (en[g]) begin
              st_reg <= adma_pkg::ST_DESC_A;
              req_reg <= 1'b1;
              we_reg <= 1'b0;
              be_reg <= adma_pkg::BE_ALL;
              addr_reg <= ptr_reg[g];
            end
          end
          adma_pkg::ST_DESC_A: begin
            if (ack) begin
              baddr_reg <= mif.rdata;
              addr_reg <= ptr_reg[g] + adma_pkg::DESC_WORD_STEP;
              st_reg <= adma_pkg::ST_DESC_B;
            end
          end
          adma_pkg::ST_DESC_B: begin
            if (ack) begin
              cnt_reg <= mif.rdata[15:0];
              eop_reg <= mif.rdata[adma_pkg::DESC_EOP_BIT];
              eot_reg <= mif.rdata[adma_pkg::DESC_EOT_BIT];
              adv_reg <= 1'b1;
              req_reg <= 1'b0;
              st_reg <= adma_pkg::ST_MOVE;
            end
          end
          adma_pkg::ST_MOVE: begin
            if (req_reg) begin
              if (ack) begin
                req_reg <= 1'b0;
                baddr_reg <= baddr_reg + adma_pkg::SAMPLE_STEP;
                cnt_reg <= (cnt_reg <= adma_pkg::SAMPLE_BYTES) ? 16'h0
                           : cnt_reg - adma_pkg::SAMPLE_BYTES;
              end
            end else if (cnt_reg == 16'h0) begin
              if (eop_reg && stat_reg[g][adma_pkg::STAT_EOP_BIT]) begin
                err_evt_reg <= 1'b1;
                st_reg <= adma_pkg::ST_PAUSE;
              end else begin
                eop_evt_reg <= eop_reg;
                st_reg <= eot_reg ? adma_pkg::ST_DONE : adma_pkg::ST_DESC_A;
                req_reg <= !eot_reg;
                we_reg <= 1'b0;
                be_reg <= adma_pkg::BE_ALL;
                addr_reg <= ptr_reg[g];
              end
            end else if (!dir[g] && !hold_full[g]) begin
              req_reg <= 1'b1;
              we_reg <= 1'b0;
              be_reg <= adma_pkg::BE_ALL;
              addr_reg <= {baddr_reg[31:2], 2'b00};
            end else if (dir[g] && hold_full[g]) begin
              req_reg <= 1'b1;
              we_reg <= 1'b1;
              be_reg <= baddr_reg[1] ? adma_pkg::BE_HIGH : adma_pkg::BE_LOW;
              wdata_reg <= {hold_data[g], hold_data[g]};
              addr_reg <= {baddr_reg[31:2], 2'b00};
            end
          end
          adma_pkg::ST_PAUSE: begin
            if (stat_rd[g]) begin
              st_reg <= eot_reg ? adma_pkg::ST_DONE : adma_pkg::ST_DESC_A;
              req_reg <= !eot_reg;
              we_reg <= 1'b0;
              be_reg <= adma_pkg::BE_ALL;
              addr_reg <= ptr_reg[g];
            end
          end
          default: begin
            if (!en[g]) begin
              st_reg <= adma_pkg::ST_IDLE;
            end
          end
        endcase
        // dropping enable with a request in flight returns to idle only once no request is outstanding
        if (!en[g] && !req_reg) begin
          st_reg <= adma_pkg::ST_IDLE;
          req_reg <= 1'b0;
        end
      end
    end

    assign mif.req[g] = req_reg;
    assign mif.we[g] = we_reg;
    assign mif.addr[g] = addr_reg;
    assign mif.wdata[g] = wdata_reg;
    assign mif.be[g] = be_reg;
    assign eop_evt[g] = eop_evt_reg;
    assign err_evt[g] = err_evt_reg;
    assign ptr_adv[g] = adv_reg;
    assign ch_st[g] = st_reg;
  end

  adma_mem_arb u_arb (
    .clk_i(CLK_SYS_I),
    .rst_n_i(RESETN_I),
    .mif(mif.arb),
    .mem_req_o(MEM_REQ_O),
    .mem_we_o(MEM_WE_O),
    .mem_addr_o(MEM_ADDR_O),
    .mem_wdata_o(MEM_WDATA_O),
    .mem_be_o(MEM_BE_O),
    .mem_gnt_i(MEM_GNT_I),
    .mem_rvalid_i(MEM_RVALID_I),
    .mem_rdata_i(MEM_RDATA_I)
  );

  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RESETN_I);

  property p_enable_start;
    (ch_st[0] == adma_pkg::ST_IDLE && en[0]) |=> (ch_st[0] == adma_pkg::ST_DESC_A && mif.req[0]);
  endproperty
  a_enable_start: assert property (p_enable_start) else $error("enable did not start fetch");

  property p_dir_we;
    (ch_st[1] == adma_pkg::ST_MOVE && mif.req[1]) |-> (mif.we[1] == dir[1]);
  endproperty
  a_dir_we: assert property (p_dir_we) else $error("transfer direction mismatch");

  property p_cmd_rsvd;
    (REG_RD_I && REG_ADDR_I == adma_pkg::CMD_OFS[0]) |=> (REG_RDATA_O[7:4] == 4'h0 && REG_RDATA_O[2:1] == 2'h0);
  endproperty
  a_cmd_rsvd: assert property (p_cmd_rsvd) else $error("reserved command bits not zero");

  property p_eop_set;
    eop_evt[0] |=> stat_reg[0][adma_pkg::STAT_EOP_BIT];
  endproperty
  a_eop_set: assert property (p_eop_set) else $error("end-of-page flag not set");

  // a status read right after the error may legally release the pause at once
  property p_err_pause;
    err_evt[0] |-> (ch_st[0] == adma_pkg::ST_PAUSE) ##1 (stat_reg[0][adma_pkg::STAT_ERR_BIT]
      && (ch_st[0] == adma_pkg::ST_PAUSE || $past(stat_rd[0]) || !$past(en[0])));
  endproperty
  a_err_pause: assert property (p_err_pause) else $error("error did not pause channel");

  property p_stat_rc;
    (stat_rd[0] && !eop_evt[0] && !err_evt[0]) |=>
      (stat_reg[0] == 2'h0 && REG_RDATA_O == {6'h00, $past(stat_reg[0])});
  endproperty
  a_stat_rc: assert property (p_stat_rc) else $error("status read did not return and clear");

  property p_ptr_adv;
    (ptr_adv[0] && !(REG_WR_I && ptr_hit(REG_ADDR_I, 0))) |=>
      (ptr_reg[0] == $past(ptr_reg[0]) + adma_pkg::PTR_STEP);
  endproperty
  a_ptr_adv: assert property (p_ptr_adv) else $error("pointer did not advance by eight");

  property p_ptr_align;
    ptr_reg[0][1:0] == 2'b00 && ptr_reg[3][1:0] == 2'b00;
  endproperty
  a_ptr_align: assert property (p_ptr_align) else $error("pointer low bits not zero");

  property p_ptr_read;
    (REG_RD_I && REG_ADDR_I == adma_pkg::PTR_OFS[0] + 8'h01) |=> (REG_RDATA_O == $past(ptr_reg[0][15:8]));
  endproperty
  a_ptr_read: assert property (p_ptr_read) else $error("pointer read not current value");

  property p_slot5_out;
    (SLOT_TICK_I && SLOT_NUM_I == adma_pkg::SLOT_PRI && en[0] && !dir[0] && hold_full[0]) |=>
      (SLOT_OUT_VLD_O && SLOT_OUT_O == $past(hold_data[0]));
  endproperty
  a_slot5_out: assert property (p_slot5_out) else $error("slot 5 sample not delivered");

  property p_eot_stop;
    (ch_st[0] == adma_pkg::ST_DONE) |=> (ch_st[0] == adma_pkg::ST_DONE || ch_st[0] == adma_pkg::ST_IDLE);
  endproperty
  a_eot_stop: assert property (p_eot_stop) else $error("channel ran past end of table");

  c_done: cover property (ch_st[0] == adma_pkg::ST_MOVE ##1 ch_st[0] == adma_pkg::ST_DONE);
  c_pause: cover property (err_evt[2]);
  c_input_write: cover property (MEM_REQ_O && MEM_WE_O && MEM_GNT_I);
endmodule
`default_nettype wire

/* verilog/adma_pkg.sv */
// constants and types shared by the audio descriptor dma channels
package adma_pkg;
  localparam int NCH = 4;
  // per-channel register offsets, channels 2..5 in index order 0..3
  localparam logic [3:0][7:0] CMD_OFS = {8'h48, 8'h40, 8'h38, 8'h30};
  localparam logic [3:0][7:0] STAT_OFS = {8'h49, 8'h41, 8'h39, 8'h31};
  localparam logic [3:0][7:0] PTR_OFS = {8'h4c, 8'h44, 8'h3c, 8'h34};
  localparam int CMD_EN_BIT = 0;
  localparam int CMD_DIR_BIT = 3;
  localparam logic [7:0] CMD_MASK = 8'h09;
  localparam logic [7:0] CMD_RST = 8'h00;
  localparam int STAT_EOP_BIT = 0;
  localparam int STAT_ERR_BIT = 1;
  localparam logic [1:0] STAT_RST = 2'h0;
  localparam logic [31:0] PTR_RST = 32'h0000_0000;
  localparam logic [31:0] PTR_STEP = 32'h0000_0008;
  localparam logic [31:0] DESC_WORD_STEP = 32'h0000_0004;
  localparam logic [31:0] SAMPLE_STEP = 32'h0000_0002;
  localparam logic [15:0] SAMPLE_BYTES = 16'h0002;
  localparam int DESC_EOP_BIT = 30;
  localparam int DESC_EOT_BIT = 31;
  localparam logic [3:0] SLOT_PRI = 4'h5;
  localparam logic [3:0] SLOT_ALT_A = 4'h6;
  localparam logic [3:0] SLOT_ALT_B = 4'hb;
  localparam logic [3:0] BE_LOW = 4'h3;
  localparam logic [3:0] BE_HIGH = 4'hc;
  localparam logic [3:0] BE_ALL = 4'hf;

  typedef enum logic [2:0] {
    ST_IDLE, ST_DESC_A, ST_DESC_B, ST_MOVE, ST_PAUSE, ST_DONE
  } adma_ch_state_t;

  typedef enum logic [1:0] {
    ARB_IDLE, ARB_GNT, ARB_DATA
  } adma_arb_state_t;
endpackage

/* verilog/adma_mem_if.sv */
// memory request bundle between the channel engines and the arbiter
`timescale 1ns/10ps
`default_nettype none
interface adma_mem_if;
  wire logic [3:0] req;
  wire logic [3:0] we;
  wire logic [3:0][31:0] addr;
  wire logic [3:0][31:0] wdata;
  wire logic [3:0][3:0] be;
  logic [3:0] ack;
  logic [31:0] rdata;
  modport chan (output req, output we, output addr, output wdata, output be,
                input ack, input rdata);
  modport arb (input req, input we, input addr, input wdata, input be,
               output ack, output rdata);
endinterface
`default_nettype wire

/* verilog/adma_mem_arb.sv */
// fixed-priority arbiter driving the shared memory master port
`timescale 1ns/10ps
`default_nettype none
module adma_mem_arb (
  input wire logic clk_i,
  input wire logic rst_n_i,
  adma_mem_if.arb mif,
  output logic mem_req_o,
  output logic mem_we_o,
  output logic [31:0] mem_addr_o,
  output logic [31:0] mem_wdata_o,
  output logic [3:0] mem_be_o,
  input wire logic mem_gnt_i,
  input wire logic mem_rvalid_i,
  input wire logic [31:0] mem_rdata_i
);
  adma_pkg::adma_arb_state_t st_reg;
  logic [1:0] owner_reg;
  logic [3:0] live;

  // a channel that was just acked still shows its old request for one cycle
  assign live = mif.req & ~mif.ack;

  function automatic logic [1:0] first_req(input logic [3:0] r);
    logic [1:0] idx;
    idx = 2'd0;
    for (int i = adma_pkg::NCH - 1; i >= 0; i--) begin
      if (r[i]) begin
        idx = 2'(i);
      end
    end
    return idx;
  endfunction

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg <= adma_pkg::ARB_IDLE;
      owner_reg <= 2'd0;
      mem_req_o <= 1'b0;
      mem_we_o <= 1'b0;
      mem_addr_o <= 32'h0;
      mem_wdata_o <= 32'h0;
      mem_be_o <= 4'h0;
      mif.ack <= 4'h0;
      mif.rdata <= 32'h0;
    end else begin
      mif.ack <= 4'h0;
      case (st_reg)
        adma_pkg::ARB_IDLE: begin
          if (|live) begin
            owner_reg <= first_req(live);
            mem_req_o <= 1'b1;
            mem_we_o <= mif.we[first_req(live)];
            mem_addr_o <= mif.addr[first_req(live)];
            mem_wdata_o <= mif.wdata[first_req(live)];
            mem_be_o <= mif.be[first_req(live)];
            st_reg <= adma_pkg::ARB_GNT;
          end
        end
        adma_pkg::ARB_GNT: begin
          if (mem_gnt_i) begin
            mem_req_o <= 1'b0;
            if (mem_we_o) begin
              mif.ack[owner_reg] <= 1'b1;
              st_reg <= adma_pkg::ARB_IDLE;
            end else begin
              st_reg <= adma_pkg::ARB_DATA;
            end
          end
        end
        default: begin
          if (mem_rvalid_i) begin
            mif.rdata <= mem_rdata_i;
            mif.ack[owner_reg] <= 1'b1;
            st_reg <= adma_pkg::ARB_IDLE;
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

/* verilog/adma_hold.sv */
// one-sample holding stage between memory and codec slot
`timescale 1ns/10ps
`default_nettype none
module adma_hold (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic push_i,
  input wire logic pop_i,
  input wire logic [15:0] data_i,
  output logic full_o,
  output logic [15:0] data_o
);
  logic take;

  // a push into a full stage without a pop is dropped, the older sample stays
  assign take = push_i && (!full_o || pop_i);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      full_o <= 1'b0;
      data_o <= 16'h0;
    end else begin
      full_o <= take || (full_o && !pop_i);
      if (take) begin
        data_o <= data_i;
      end
    end
  end
endmodule
`default_nettype wire

/* tb/adma_mem_model.sv */
// behavioural system memory answering the channel memory port
`timescale 1ns/10ps
`default_nettype none
module adma_mem_model (
  input wire logic clk_i,
  input wire logic req_i,
  input wire logic we_i,
  input wire logic [31:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] be_i,
  output logic gnt_o,
  output logic rvalid_o,
  output logic [31:0] rdata_o
);
  logic [31:0] mem [logic [31:0]];
  logic [31:0] pa;
  logic [31:0] m;
  logic [31:0] a;
  logic pend = 1'b0;
  int dly = 0;
  initial begin
    gnt_o = 1'b0;
    rvalid_o = 1'b0;
    rdata_o = 32'h0;
  end
  always @(posedge clk_i) begin
    gnt_o <= 1'b0;
    rvalid_o <= 1'b0;
    // idle data lines toggle so a stale word is never mistaken for an answer
    rdata_o <= ~rdata_o;
    if (pend) begin
      if (dly == 0) begin
        rvalid_o <= 1'b1;
        rdata_o <= mem.exists(pa) ? mem[pa] : 32'h0;
        pend <= 1'b0;
      end else begin
        dly <= dly - 1;
      end
    end else if (req_i && !gnt_o && $urandom_range(1, 0) == 1) begin
      gnt_o <= 1'b1;
      a = {addr_i[31:2], 2'h0};
      if (we_i) begin
        m = mem.exists(a) ? mem[a] : 32'h0;
        for (int b = 0; b < 4; b++) begin
          if (be_i[b]) begin
            m[b*8+:8] = wdata_i[b*8+:8];
          end
        end
        mem[a] = m;
      end else begin
        pa <= a;
        pend <= 1'b1;
        dly <= $urandom_range(2, 0);
      end
    end
  end
endmodule
`default_nettype wire

/* tb/tb.sv */
// self-checking bench for the four audio dma channels
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic clk = 0, rst_n = 0, wr = 0, rd = 0, alt4 = 0, alt5 = 0, tick = 0;
  logic [7:0] addr = 0, wd = 0, rdat;
  logic [3:0] num = 0, mbe;
  logic [15:0] sin = 0, sout;
  logic vld, mreq, mwe, gnt, rv;
  logic [31:0] ma, mw, mr;
  int error_cnt = 0, compares = 0, cyc = 0;
  initial forever #10 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      error_cnt++;
      close_out();
    end
  end
  adma_top adma_top_inst (.CLK_SYS_I(clk), .RESETN_I(rst_n), .REG_ADDR_I(addr), .REG_WR_I(wr),
    .REG_RD_I(rd), .REG_WDATA_I(wd), .REG_RDATA_O(rdat), .CH4_ALT_SLOT_I(alt4),
    .CH5_ALT_SLOT_I(alt5), .SLOT_TICK_I(tick), .SLOT_NUM_I(num), .SLOT_IN_I(sin),
    .SLOT_OUT_O(sout), .SLOT_OUT_VLD_O(vld), .MEM_REQ_O(mreq), .MEM_WE_O(mwe),
    .MEM_ADDR_O(ma), .MEM_WDATA_O(mw), .MEM_BE_O(mbe), .MEM_GNT_I(gnt),
    .MEM_RVALID_I(rv), .MEM_RDATA_I(mr));
  adma_mem_model adma_mem_model_inst (.clk_i(clk), .req_i(mreq), .we_i(mwe), .addr_i(ma),
    .wdata_i(mw), .be_i(mbe), .gnt_o(gnt), .rvalid_o(rv), .rdata_o(mr));
  task close_out;
    if (error_cnt == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // only enable and direction survive a command write
  function automatic logic [7:0] exp_cmd(input logic [7:0] w);
    return {4'h0, w[adma_pkg::CMD_DIR_BIT], 2'h0, w[adma_pkg::CMD_EN_BIT]};
  endfunction
  // pointer after n descriptor entries have been fetched
  function automatic logic [31:0] exp_ptr(input logic [31:0] b, input int n);
    return b + adma_pkg::PTR_STEP * 32'(n);
  endfunction
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  // single-byte accesses; wrp and rdp use four of them per pointer
  task wrb(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #2 addr = a; wd = d; wr = 1;
    @(posedge clk);
    #2 wr = 0;
  endtask
  task rdb(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    #2 addr = a; rd = 1;
    @(posedge clk);
    #2 rd = 0; d = rdat;
  endtask
  task wrp(input logic [7:0] a, input logic [31:0] v);
    for (int i = 0; i < 4; i++) wrb(a + i, v[8*i+:8]);
  endtask
  task rdp(input logic [7:0] a, output logic [31:0] v);
    logic [7:0] b;
    for (int i = 0; i < 4; i++) begin
      rdb(a + i, b);
      v[8*i+:8] = b;
    end
  endtask
  // two-entry table, four samples, both entries flagged end-of-page
  task run(input int c, input logic dir, input logic [3:0] s);
    logic [31:0] base, p, w0, w1;
    logic [15:0] smp [4];
    logic [7:0] b;
    int k;
    base = 32'h1000 * (c + 1);
    w0 = $urandom();
    w1 = $urandom();
    if (dir) begin
      {smp[1], smp[0]} = w0;
      {smp[3], smp[2]} = w1;
    end else begin
      {smp[1], smp[0]} = w0;
      {smp[3], smp[2]} = w1;
      adma_mem_model_inst.mem[base + 32'h40] = w0;
      adma_mem_model_inst.mem[base + 32'h80] = w1;
    end
    adma_mem_model_inst.mem[base] = base + 32'h40;
    adma_mem_model_inst.mem[base + 4] = 32'h4000_0004;
    adma_mem_model_inst.mem[base + 8] = base + 32'h80;
    adma_mem_model_inst.mem[base + 12] = 32'hc000_0004;
    wrp(adma_pkg::PTR_OFS[c], base);
    wrb(adma_pkg::CMD_OFS[c], {4'h0, dir, 3'h1});
    k = 0;
    for (int t = 0; t < 200 && k < 4; t++) begin
      repeat (30) @(posedge clk);
      #2 tick = 1; num = s; sin = smp[k];
      @(posedge clk);
      #2 tick = 0;
      if (dir) k++;
      else if (vld === 1'b1) begin
        chk("slot_out", smp[k], sout);
        k++;
      end
    end
    chk("sample_count", 4, k);
    repeat (60) @(posedge clk);
    rdb(adma_pkg::STAT_OFS[c], b);
    chk("status", 8'h03, b);
    rdb(adma_pkg::STAT_OFS[c], b);
    chk("status", 8'h00, b);
    repeat (20) @(posedge clk);
    rdp(adma_pkg::PTR_OFS[c], p);
    chk("pointer", exp_ptr(base, 2), p);
    if (dir) begin
      chk("mem", w0, adma_mem_model_inst.mem[base + 32'h40]);
      chk("mem", w1, adma_mem_model_inst.mem[base + 32'h80]);
    end
    wrb(adma_pkg::CMD_OFS[c], 8'h00);
  endtask
  initial begin
    logic [7:0] b;
    logic [31:0] p, v;
    void'($urandom(32'h1241));
    repeat (10) @(posedge clk);
    #2 rst_n = 1;
    for (int c = 0; c < 4; c++) begin
      rdb(adma_pkg::CMD_OFS[c], b);
      chk("cmd", 0, b);
      rdb(adma_pkg::STAT_OFS[c], b);
      chk("status", 0, b);
      rdp(adma_pkg::PTR_OFS[c], p);
      chk("pointer", 0, p);
      v = $urandom() & 32'hf6;
      wrb(adma_pkg::CMD_OFS[c], v[7:0]);
      rdb(adma_pkg::CMD_OFS[c], b);
      chk("cmd", exp_cmd(v[7:0]), b);
      wrb(adma_pkg::CMD_OFS[c], 8'h00);
      v = $urandom();
      wrp(adma_pkg::PTR_OFS[c], v);
      rdp(adma_pkg::PTR_OFS[c], p);
      chk("pointer", v & 32'hffff_fffc, p);
    end
    wrb(8'h32, 8'h5a);
    rdb(8'h32, b);
    chk("unmapped", 0, b);
    run(0, 1'b0, 4'h5);
    alt4 = 1;
    run(2, 1'b0, 4'hb);
    run(1, 1'b1, 4'h5);
    run(3, 1'b1, 4'h6);
    // the other setting of each slot select, so both pins see both values
    alt4 = 0;
    alt5 = 1;
    run(2, 1'b0, 4'h6);
    run(3, 1'b1, 4'hb);
    close_out();
  end
endmodule
`default_nettype wire
